// ==== inc/pps_pkg.sv ====
/*
 * shared constants for the profile position status word block:
 * register offsets, status bit positions, reset values, alarm codes.
 * assumes a 32-bit classic wishbone register bus.
 */
package pps_pkg;
    // register byte offsets
    localparam logic [7:0]  REG_STATUS_OFS   = 8'h00;
    localparam logic [7:0]  REG_FE_WIN_OFS   = 8'h04;

    // status word bit positions
    localparam int          SW_TORQUE_BIT    = 15;
    localparam int          SW_SPARE_HI_BIT  = 14;
    localparam int          SW_FOLLOW_BIT    = 13;
    localparam int          SW_ACK_BIT       = 12;
    localparam int          SW_LIMIT_BIT     = 11;
    localparam int          SW_TARGET_BIT    = 10;
    localparam int          SW_REMOTE_BIT    = 9;
    localparam int          SW_SPARE_LO_BIT  = 8;
    localparam int          SW_WARN_BIT      = 7;

    // control word bit positions
    localparam int          CW_NEW_SP_BIT    = 4;
    localparam int          CW_HALT_BIT      = 8;

    // alarm codes that end a following error
    localparam logic [7:0]  ALM_DEVIATION    = 8'h10;
    localparam logic [7:0]  ALM_OVERLOAD     = 8'h30;

    // reset values
    localparam logic [15:0] STATUS_RST       = 16'h0000;
    localparam logic [31:0] FE_WIN_RST       = 32'h0000_ffff;
endpackage

// ==== rtl/pps_flag.sv ====
/*
 * one sticky flag: set wins over clear in the same cycle.
 * assumes one synchronous active-high reset.
 */
`timescale 1ns/1ps
module pps_flag (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      q_o
);
    logic q_ff;
    logic nxt_q;

    // set beats clear so no event is lost
    always_comb begin
        nxt_q = set_i | (q_ff & ~clr_i);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_ff <= 1'b0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign q_o = q_ff;
endmodule

// ==== rtl/pps_wb_regs.sv ====
/*
 * classic wishbone slave for the status block: status word (ro) and
 * following error window (rw, byte lanes). unmapped reads give zero,
 * unmapped writes are dropped; every access is acked.
 * assumes the master holds the request until it samples ack.
 */
`timescale 1ns/1ps
module pps_wb_regs (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        we_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    input  wire logic [15:0] status_i,
    output logic [31:0]      fe_window_o
);
    logic        ack_ff;
    logic        nxt_ack;
    logic [31:0] rdat_ff;
    logic [31:0] nxt_rdat;
    logic [31:0] win_ff;
    logic [31:0] nxt_win;
    logic        req;

    // answer one cycle after the request; ack drops the cycle after
    assign req = cyc_i & stb_i & ~ack_ff;

    always_comb begin
        nxt_ack  = req;
        nxt_rdat = rdat_ff;
        nxt_win  = win_ff;
        if (req) begin
            nxt_rdat = 32'h0000_0000;
            case (adr_i)
                pps_pkg::REG_STATUS_OFS: nxt_rdat = {16'h0000, status_i};
                pps_pkg::REG_FE_WIN_OFS: nxt_rdat = win_ff;
                default:                 nxt_rdat = 32'h0000_0000;
            endcase
            if (we_i && adr_i == pps_pkg::REG_FE_WIN_OFS) begin
                for (int b = 0; b < 4; b++) begin
                    if (sel_i[b]) begin
                        nxt_win[b*8 +: 8] = dat_i[b*8 +: 8];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0000_0000;
            win_ff  <= pps_pkg::FE_WIN_RST;
        end else begin
            ack_ff  <= nxt_ack;
            rdat_ff <= nxt_rdat;
            win_ff  <= nxt_win;
        end
    end

    assign ack_o       = ack_ff;
    assign dat_o       = rdat_ff;
    assign fe_window_o = win_ff;

    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_ff |=> !ack_ff)
        else $error("ack held longer than one cycle");
endmodule

// ==== rtl/pps_status_top.sv ====
/*
 * status word generator for profile position mode: torque limit,
 * following error, set point acknowledge, internal limit, target
 * reached, remote and warning bits, readable over wishbone.
 * assumes all drive inputs are synchronous to clk_i and that bits
 * 6..0 (drive state machine) are merged in by another block.
 */
`timescale 1ns/1ps
module pps_status_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        we_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // host control word and drive state
    input  wire logic [15:0] ctrl_word_i,
    input  wire logic        op_enabled_i,
    input  wire logic        stop_input_i,
    // motion feedback
    input  wire logic        torque_limit_reached_i,
    input  wire logic [31:0] pos_deviation_i,
    input  wire logic        alarm_clear_i,
    input  wire logic [7:0]  alarm_code_i,
    input  wire logic        motion_done_i,
    input  wire logic        motion_abort_i,
    input  wire logic        cmd_speed_zero_i,
    // internal limit sources
    input  wire logic        forward_limit_sensor_i,
    input  wire logic        reverse_limit_sensor_i,
    input  wire logic        forward_motion_block_input_i,
    input  wire logic        reverse_motion_block_input_i,
    input  wire logic        software_limit_i,
    input  wire logic        mechanical_limit_i,
    // misc status sources
    input  wire logic        init_done_i,
    input  wire logic [7:0]  info_cause_i,
    // outputs
    output logic [15:0]      status_word_o,
    output logic             start_accept_o
);
    // magnitude of a signed deviation
    function automatic logic [31:0] abs32(input logic [31:0] v);
        abs32 = v[31] ? 32'(~v + 32'h0000_0001) : v;
    endfunction

    logic [31:0] fe_window;
    logic        new_sp;
    logic        halt;
    logic        start_accept;
    logic        fe_exceed;
    logic        fe_alarm_clr;
    logic        fe_flag;
    logic        ack_flag;
    logic        ack_clr;
    logic        limit_any;

    logic        new_sp_ff;
    logic        tr_ff;
    logic        nxt_tr;
    logic        start_ff;
    logic        nxt_start;
    logic [15:0] status_ff;
    logic [15:0] nxt_status;

    assign new_sp = ctrl_word_i[pps_pkg::CW_NEW_SP_BIT];
    assign halt   = ctrl_word_i[pps_pkg::CW_HALT_BIT];

    // register bus slave; window steers the following error check
    pps_wb_regs u_regs (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .adr_i       (adr_i),
        .dat_i       (dat_i),
        .sel_i       (sel_i),
        .we_i        (we_i),
        .cyc_i       (cyc_i),
        .stb_i       (stb_i),
        .dat_o       (dat_o),
        .ack_o       (ack_o),
        .status_i    (status_ff),
        .fe_window_o (fe_window)
    );

    // start accepted only on a rising set point, no halt, no stop,
    // and in operation enabled
    assign start_accept = new_sp & ~new_sp_ff & ~halt
                        & ~stop_input_i & op_enabled_i;

    // edge memory of the new set point bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            new_sp_ff <= 1'b0;
        end else begin
            new_sp_ff <= new_sp;
        end
    end

    // following error: sticky until a matching alarm is cleared
    assign fe_exceed    = abs32(pos_deviation_i) > fe_window;
    assign fe_alarm_clr = alarm_clear_i
                        & (alarm_code_i == pps_pkg::ALM_DEVIATION
                        |  alarm_code_i == pps_pkg::ALM_OVERLOAD);

    pps_flag u_fe_flag (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .set_i (fe_exceed),
        .clr_i (fe_alarm_clr),
        .q_o   (fe_flag)
    );

    // acknowledge: bit drop or leaving operation enabled clears it;
    // a clear cannot meet a set since accept needs both high
    assign ack_clr = ~new_sp | ~op_enabled_i;

    pps_flag u_ack_flag (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .set_i (start_accept),
        .clr_i (ack_clr),
        .q_o   (ack_flag)
    );

    // any internal limit source
    assign limit_any = forward_limit_sensor_i
                     | reverse_limit_sensor_i
                     | forward_motion_block_input_i
                     | reverse_motion_block_input_i
                     | software_limit_i
                     | mechanical_limit_i;

    // target reached: halt mode tracks zero speed, otherwise a
    // sticky bit set by clean completion and cleared by a new start
    always_comb begin
        nxt_tr = tr_ff;
        if (halt) begin
            nxt_tr = cmd_speed_zero_i;
        end else if (start_accept) begin
            nxt_tr = 1'b0;
        end else if (motion_done_i && !motion_abort_i) begin
            nxt_tr = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tr_ff <= 1'b0;
        end else begin
            tr_ff <= nxt_tr;
        end
    end

    // assemble the word; drive state bits stay zero here
    always_comb begin
        nxt_status = pps_pkg::STATUS_RST;
        nxt_status[pps_pkg::SW_TORQUE_BIT] = torque_limit_reached_i;
        nxt_status[pps_pkg::SW_FOLLOW_BIT] = fe_flag;
        nxt_status[pps_pkg::SW_ACK_BIT]    = ack_flag;
        nxt_status[pps_pkg::SW_LIMIT_BIT]  = limit_any;
        nxt_status[pps_pkg::SW_TARGET_BIT] = tr_ff;
        nxt_status[pps_pkg::SW_REMOTE_BIT] = init_done_i;
        nxt_status[pps_pkg::SW_WARN_BIT]   = |info_cause_i;
        nxt_start = start_accept;
    end

    // one register stage so every output comes from a flip-flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_ff <= pps_pkg::STATUS_RST;
            start_ff  <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            start_ff  <= nxt_start;
        end
    end

    assign status_word_o  = status_ff;
    assign start_accept_o = start_ff;

    // checks
    sequence s_clean_done;
        !halt && motion_done_i && !motion_abort_i && !start_accept;
    endsequence

    sequence s_halt_still;
        halt ##1 halt;
    endsequence

    // accepted start: pulse first, acknowledge bit one cycle later
    sequence s_ack_seen;
        start_accept_o ##1 status_word_o[pps_pkg::SW_ACK_BIT];
    endsequence

    a_torque_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 status_word_o[pps_pkg::SW_TORQUE_BIT] == $past(torque_limit_reached_i))
        else $error("torque bit does not follow input");

    a_follow_set: assert property (@(posedge clk_i) disable iff (rst_i)
        fe_exceed |-> ##2 status_word_o[pps_pkg::SW_FOLLOW_BIT])
        else $error("following error bit not set");

    a_follow_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (fe_alarm_clr && !fe_exceed) |-> ##2 !status_word_o[pps_pkg::SW_FOLLOW_BIT])
        else $error("following error bit not cleared by alarm");

    a_follow_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (fe_flag && !fe_alarm_clr) |=> fe_flag)
        else $error("following error dropped without alarm clear");

    a_follow_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (!fe_flag && !fe_exceed) |=> !fe_flag)
        else $error("following error set without excess deviation");

    a_ack_rise: assert property (@(posedge clk_i) disable iff (rst_i)
        start_accept |=> s_ack_seen)
        else $error("acknowledge not raised after accepted start");

    a_start_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        !start_accept |=> !start_accept_o)
        else $error("start pulse without accepted start");

    // the acknowledge must not drop while the host still holds bit4 and operation stays enabled
    a_ack_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (ack_flag && new_sp && op_enabled_i) |=> ack_flag)
        else $error("acknowledge dropped while set point held");

    a_ack_no_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ack_flag && !start_accept) |=> !ack_flag)
        else $error("acknowledge rose without accepted start");

    a_ack_drop_sp: assert property (@(posedge clk_i) disable iff (rst_i)
        !new_sp |-> ##2 !status_word_o[pps_pkg::SW_ACK_BIT])
        else $error("acknowledge not dropped with set point bit");

    a_ack_drop_op: assert property (@(posedge clk_i) disable iff (rst_i)
        !op_enabled_i |-> ##2 !status_word_o[pps_pkg::SW_ACK_BIT])
        else $error("acknowledge held outside operation enabled");

    a_limit_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 status_word_o[pps_pkg::SW_LIMIT_BIT] == $past(limit_any))
        else $error("internal limit bit wrong");

    a_target_done: assert property (@(posedge clk_i) disable iff (rst_i)
        s_clean_done |-> ##2 status_word_o[pps_pkg::SW_TARGET_BIT])
        else $error("target reached not raised on completion");

    a_target_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (!halt && tr_ff && !start_accept) |=> tr_ff)
        else $error("target reached lost without new start");

    a_target_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        (!halt && !tr_ff && motion_abort_i) |=> !tr_ff)
        else $error("target reached raised by interrupted move");

    a_target_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (start_accept && !halt) |-> ##2 !status_word_o[pps_pkg::SW_TARGET_BIT])
        else $error("target reached not cleared by new start");

    a_target_halt: assert property (@(posedge clk_i) disable iff (rst_i)
        s_halt_still |=> tr_ff == $past(cmd_speed_zero_i))
        else $error("target reached wrong during halt");

    a_target_decel: assert property (@(posedge clk_i) disable iff (rst_i)
        (halt && !cmd_speed_zero_i) |-> ##2 !status_word_o[pps_pkg::SW_TARGET_BIT])
        else $error("target reached high during deceleration");

    a_remote_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        init_done_i |=> status_word_o[pps_pkg::SW_REMOTE_BIT])
        else $error("remote bit not set after initialisation");

    a_remote_low: assert property (@(posedge clk_i) disable iff (rst_i)
        !init_done_i |=> !status_word_o[pps_pkg::SW_REMOTE_BIT])
        else $error("remote bit set before initialisation");

    a_warn_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 status_word_o[pps_pkg::SW_WARN_BIT] == $past(|info_cause_i))
        else $error("warning bit does not track causes");

    a_spare_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        !status_word_o[pps_pkg::SW_SPARE_HI_BIT] && !status_word_o[pps_pkg::SW_SPARE_LO_BIT])
        else $error("undefined status bits not zero");

    // drive state bits are merged elsewhere, so they must stay clear here
    a_state_bits_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        status_word_o[6:0] == 7'h00)
        else $error("drive state bits not zero");
endmodule

// ==== tb/pps_host_model.sv ====
/*
 * host side model: writes the control word once per cycle from the
 * bench's go and halt requests and watches the torque bit.
 * assumes one clock shared with the status block.
 */
`timescale 1ns/1ps
module pps_host_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        go_i,
    input  wire logic        halt_i,
    input  wire logic [15:0] status_word_i,
    output logic [15:0]      ctrl_word_o,
    output logic             push_done_o
);
    logic torque_ff;

    // registered like a fieldbus frame, so bit4 edges lag go by one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_word_o <= 16'h0000;
            torque_ff   <= 1'b0;
        end else begin
            ctrl_word_o                         <= 16'h0000;
            ctrl_word_o[pps_pkg::CW_NEW_SP_BIT] <= go_i;
            ctrl_word_o[pps_pkg::CW_HALT_BIT]   <= halt_i;
            torque_ff                           <= status_word_i[pps_pkg::SW_TORQUE_BIT];
        end
    end

    // torque bit rising is taken as push motion finished
    assign push_done_o = status_word_i[pps_pkg::SW_TORQUE_BIT] & ~torque_ff;
endmodule

// ==== tb/pps_status_top_tb.sv ====
/*
 * self-checking bench for the status word block: bus, direct bits,
 * following error, set point handshake and target reached.
 * assumes the block answers wishbone in one cycle, all flops on clk_i.
 */
`timescale 1ns/1ps
module pps_status_top_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
    logic [7:0]  adr_i = 8'h00, acode = 8'h00, info = 8'h00;
    logic [31:0] dat_i = 32'h0, dev = 32'h0, dat_o;
    logic [15:0] ctrl_word, status_word_o;
    logic        op_en = 1'b0, stop = 1'b0, torque = 1'b0, aclr = 1'b0, done = 1'b0, abort = 1'b0;
    logic        spd0 = 1'b0, init = 1'b0, go = 1'b0, halt = 1'b0, ack_o, start_accept_o, push_done;
    logic [5:0]  lim = 6'h00;
    logic [31:0] q;
    int          fails = 0, n_compared = 0, n_acc = 0, n_push = 0;

    pps_status_top uut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(4'hf),
        .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
        .ctrl_word_i(ctrl_word), .op_enabled_i(op_en), .stop_input_i(stop),
        .torque_limit_reached_i(torque), .pos_deviation_i(dev), .alarm_clear_i(aclr),
        .alarm_code_i(acode), .motion_done_i(done), .motion_abort_i(abort), .cmd_speed_zero_i(spd0),
        .forward_limit_sensor_i(lim[0]), .reverse_limit_sensor_i(lim[1]),
        .forward_motion_block_input_i(lim[2]), .reverse_motion_block_input_i(lim[3]),
        .software_limit_i(lim[4]), .mechanical_limit_i(lim[5]), .init_done_i(init),
        .info_cause_i(info), .status_word_o(status_word_o), .start_accept_o(start_accept_o));

    pps_host_model host (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .halt_i(halt),
        .status_word_i(status_word_o), .ctrl_word_o(ctrl_word), .push_done_o(push_done));

    // 125 MHz clock
    always #4 clk_i = ~clk_i;

    // pulse counters, sampled before the edge's updates land
    always @(posedge clk_i) begin
        if (start_accept_o === 1'b1) n_acc++;
        if (push_done === 1'b1) n_push++;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one classic cycle; request held until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        if (i == 20) begin
            fails++;
            results();
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic alarm(input logic [7:0] code);
        acode <= code;
        aclr  <= 1'b1;
        step(1);
        aclr  <= 1'b0;
        step(4);
    endtask

    task automatic t_regs();
        wb(1'b0, pps_pkg::REG_FE_WIN_OFS, 32'h0);
        check("window reset", q, pps_pkg::FE_WIN_RST);
        wb(1'b1, pps_pkg::REG_STATUS_OFS, 32'hffff_ffff);
        wb(1'b0, pps_pkg::REG_STATUS_OFS, 32'h0);
        check("status ro", q, 32'h0000_0000);
        wb(1'b0, 8'h08, 32'h0);
        check("unmapped", q, 32'h0000_0000);
    endtask

    task automatic t_direct();
        torque <= 1'b1;
        step(3);
        check("torque on", status_word_o, 16'h8000);
        check("push done", n_push, 1);
        torque <= 1'b0;
        step(3);
        check("torque off", status_word_o, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            lim <= 6'h01 << i;
            step(3);
            check("limit", status_word_o, 16'h0800);
        end
        lim <= 6'h00;
        init <= 1'b1;
        step(3);
        check("remote", status_word_o, 16'h0200);
        for (int i = 0; i < 8; i++) begin
            info <= 8'h01 << i;
            step(3);
            check("warning", status_word_o, 16'h0280);
        end
        info <= 8'h00;
        step(3);
        wb(1'b0, pps_pkg::REG_STATUS_OFS, 32'h0);
        check("warning clear", q, 32'h0000_0200);
    endtask

    task automatic t_follow();
        wb(1'b1, pps_pkg::REG_FE_WIN_OFS, 32'h0000_0064);
        wb(1'b0, pps_pkg::REG_FE_WIN_OFS, 32'h0);
        check("window rw", q, 32'h0000_0064);
        dev <= 32'h0000_0064;
        step(4);
        check("dev at window", status_word_o[13], 1'b0);
        dev <= 32'hffff_ff9b;
        step(4);
        check("dev over window", status_word_o[13], 1'b1);
        dev <= 32'h0;
        alarm(8'h20);
        check("other alarm", status_word_o[13], 1'b1);
        alarm(pps_pkg::ALM_DEVIATION);
        check("dev alarm clr", status_word_o[13], 1'b0);
        dev <= 32'h0000_0065;
        step(3);
        check("dev over again", status_word_o[13], 1'b1);
        dev <= 32'h0;
        alarm(pps_pkg::ALM_OVERLOAD);
        check("ovl alarm clr", status_word_o[13], 1'b0);
    endtask

    task automatic t_ack();
        int n0;
        n0 = n_acc;
        go <= 1'b1;
        step(5);
        check("ack set", status_word_o[12], 1'b1);
        go <= 1'b0;
        step(4);
        check("ack drop", status_word_o[12], 1'b0);
        // halt, stop input and disabled state each refuse a start
        for (int i = 0; i < 3; i++) begin
            halt  <= (i == 0);
            stop  <= (i == 1);
            op_en <= (i != 2);
            step(2);
            go <= 1'b1;
            step(5);
            check("refused", status_word_o[12], 1'b0);
            go <= 1'b0;
            step(2);
        end
        halt  <= 1'b0;
        stop  <= 1'b0;
        op_en <= 1'b1;
        step(2);
        check("accept count", n_acc, n0 + 1);
        go <= 1'b1;
        step(5);
        check("ack set again", status_word_o[12], 1'b1);
        op_en <= 1'b0;
        step(4);
        check("ack op off", status_word_o[12], 1'b0);
        go <= 1'b0;
        op_en <= 1'b1;
        step(3);
    endtask

    task automatic t_target();
        go <= 1'b1;
        step(3);
        go <= 1'b0;
        step(3);
        check("moving", status_word_o[10], 1'b0);
        done <= 1'b1;
        step(1);
        done <= 1'b0;
        step(4);
        check("reached", status_word_o[10], 1'b1);
        go <= 1'b1;
        step(5);
        check("restart", status_word_o[10], 1'b0);
        go <= 1'b0;
        // completion flagged together with an interruption must not count
        abort <= 1'b1;
        done  <= 1'b1;
        step(1);
        abort <= 1'b0;
        done  <= 1'b0;
        step(4);
        check("aborted", status_word_o[10], 1'b0);
        done <= 1'b1;
        step(1);
        done <= 1'b0;
        step(4);
        check("reached again", status_word_o[10], 1'b1);
        halt <= 1'b1;
        step(4);
        check("decelerating", status_word_o[10], 1'b0);
        spd0 <= 1'b1;
        step(4);
        check("halted", status_word_o[10], 1'b1);
    endtask

    // reset for 16 cycles, then the scenarios in turn
    initial begin
        step(16);
        rst_i <= 1'b0;
        op_en <= 1'b1;
        step(2);
        t_regs();
        t_direct();
        t_follow();
        t_ack();
        t_target();
        results();
    end
endmodule
